// >>> dcsr_cal_path.sv
// Calibration datapath: gain scaling, zero offset and saturation
`timescale 1ns/10ps
module dcsr_cal_path
  import dcsr_pkg::*;
#(
  parameter int unsigned CODE_BITS = 16
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Code and trims
  input wire logic cal_enable,
  input wire logic [15:0] code,
  input wire logic [15:0] gain,
  input wire logic [15:0] zero,
  // Result
  output logic [15:0] cal_code_r
);

  localparam logic [18:0] SAT_MAX = 19'h0FFFF;

  logic [16:0] gain_scale;
  logic [32:0] product;
  logic signed [18:0] sum;
  logic [15:0] cal_nxt;

  // Full-scale gain trim gives unity; zero trim gives the smallest scale
  always_comb
  begin
    gain_scale = {1'b0, gain} + 17'h00001;
    product = {17'h00000, code} * {16'h0000, gain_scale};
    sum = $signed({2'b00, product[32:16]}) + $signed({{3{zero[15]}}, zero});
    if (!cal_enable)
    begin
      cal_nxt = code;
    end
    else if (sum < 0)
    begin
      cal_nxt = 16'h0000;
    end
    else if (sum > $signed(SAT_MAX))
    begin
      cal_nxt = 16'hFFFF;
    end
    else
    begin
      cal_nxt = sum[15:0];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cal_code_r <= CODE_RESET;
    end
    else
    begin
      cal_code_r <= cal_nxt & dcsr_res_mask(CODE_BITS);
    end
  end

endmodule

// >>> dcsr_host_model.sv
// Host model issuing register writes and reads
`timescale 1ns/10ps
module dcsr_host_model
  import dcsr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register ports
  output logic reg_wr_en,
  output logic [7:0] reg_wr_addr,
  output logic [15:0] reg_wr_data,
  output logic reg_rd_en,
  output logic [7:0] reg_rd_addr,
  input wire logic [15:0] reg_rd_data,
  input wire logic reg_rd_valid
);
  initial
  begin
    reg_wr_en = 1'b0;
    reg_wr_addr = 8'h00;
    reg_wr_data = 16'h0000;
    reg_rd_en = 1'b0;
    reg_rd_addr = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_wr_en = 1'b1;
    reg_wr_addr = a;
    reg_wr_data = (a == ADDR_CONFIG) ? (d & 16'h07BF) : d;
    @(posedge clk);
    #1;
    reg_wr_en = 1'b0;
    reg_wr_data = ~reg_wr_data;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk);
    #1;
    reg_rd_en = 1'b1;
    reg_rd_addr = a;
    @(posedge clk);
    #1;
    reg_rd_en = 1'b0;
    reg_rd_addr = ~a;
    ok = reg_rd_valid;
    d = reg_rd_data;
  endtask
endmodule

// >>> dcsr_pkg.sv
// Constants shared by the configuration and status register bank
package dcsr_pkg;

  localparam int unsigned DCSR_DATA_W = 16;
  localparam int unsigned DCSR_ADDR_W = 8;

  // Register addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h55;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h56;
  localparam logic [7:0] ADDR_CONFIG = 8'h57;
  localparam logic [7:0] ADDR_CODE = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_GAIN = 8'h58;
  localparam logic [7:0] ADDR_ZERO = 8'h59;

  // Control register fields
  localparam int unsigned CTL_OUTEN = 12;
  localparam int unsigned CTL_RANGE_LSB = 0;
  localparam logic [15:0] CTL_WRITE_MASK = 16'hFFF7;
  localparam logic [2:0] RANGE_4_20MA = 3'h5;
  localparam int unsigned RANGE_CURRENT_BIT = 2;

  // Configuration register fields
  localparam int unsigned CFG_CUR_RANGE_LSB = 9;
  localparam int unsigned CFG_DUAL = 8;
  localparam int unsigned CFG_PULLDOWN = 7;
  localparam int unsigned CFG_CAL = 5;
  localparam int unsigned CFG_MODEM = 4;
  localparam int unsigned CFG_FRAME = 3;
  localparam int unsigned CFG_WD_EN = 2;
  localparam int unsigned CFG_WD_PD_LSB = 0;
  localparam logic [15:0] CFG_WRITE_MASK = 16'h07BF;

  // Soft reset trigger bit
  localparam int unsigned RST_TRIGGER_BIT = 0;

  // Status bit positions
  localparam int unsigned ST_FRAME = 4;
  localparam int unsigned ST_WATCHDOG = 3;
  localparam int unsigned ST_LOOP = 2;
  localparam int unsigned ST_SLEW = 1;
  localparam int unsigned ST_TEMP = 0;

  // Reset values
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [15:0] GAIN_RESET = 16'h0000;
  localparam logic [15:0] ZERO_RESET = 16'h0000;

  // Keeps only the bits that the converter resolution implements
  function automatic logic [15:0] dcsr_res_mask(input int unsigned bits);
    logic [15:0] ones;
    ones = 16'hFFFF;
    return ones << (DCSR_DATA_W - bits);
  endfunction

endpackage

// >>> dcsr_regs.sv
// Configuration, code, trim, soft reset and alarm status register bank
`timescale 1ns/10ps
module dcsr_regs
  import dcsr_pkg::*;
#(
  parameter int unsigned CODE_BITS = 16
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register write port from the command decoder
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_addr,
  input wire logic [15:0] reg_wr_data,
  // Register read port
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_addr,
  output logic [15:0] reg_rd_data,
  output logic reg_rd_valid,
  // Fault monitors
  input wire logic monitor_tick,
  input wire logic frame_error,
  input wire logic watchdog_timeout,
  input wire logic loop_fault_cond,
  input wire logic overtemp_cond,
  input wire logic slew_busy,
  // Output stage controls
  output logic voltage_out_enable,
  output logic current_out_enable,
  output logic [2:0] voltage_range,
  output logic [1:0] current_range,
  output logic sense_pulldown_enable,
  output logic modem_coupling_active,
  output logic frame_check_enable,
  output logic watchdog_enable,
  output logic [1:0] watchdog_period_select,
  output logic [15:0] calibrated_code,
  // Housekeeping
  output logic soft_reset_active,
  output logic alarm_any
);

  localparam logic [15:0] RES_MASK = dcsr_res_mask(CODE_BITS);

  logic [15:0] control_r;
  logic [15:0] config_r;
  logic [15:0] code_r;
  logic [15:0] gain_r;
  logic [15:0] zero_r;
  logic trigger_r;
  logic frame_fault_r;
  logic watchdog_fault_r;
  logic loop_fault_r;
  logic overtemp_fault_r;
  logic slewing_r;
  logic [15:0] rd_data_r;
  logic rd_valid_r;

  logic wr_control;
  logic wr_config;
  logic wr_code;
  logic wr_gain;
  logic wr_zero;
  logic wr_reset;
  logic range_changed;
  logic [2:0] range_now;
  logic dual_mode;
  logic [15:0] status_word;
  logic [15:0] rd_data_nxt;

  // One decode used for every write strobe
  function automatic logic write_hit(input logic en, input logic [7:0] addr,
                                     input logic [7:0] target);
    return en && (addr == target);
  endfunction

  // Alarm update: a tick samples the condition; set beats the soft clear
  function automatic logic alarm_next(input logic cur, input logic cond,
                                      input logic tick, input logic clr);
    logic res;
    res = cur;
    if (tick && cond)
    begin
      res = 1'b1;
    end
    else if (tick)
    begin
      res = 1'b0;
    end
    else if (clr)
    begin
      res = 1'b0;
    end
    return res;
  endfunction

  always_comb
  begin
    wr_control = write_hit(reg_wr_en, reg_wr_addr, ADDR_CONTROL);
    wr_config = write_hit(reg_wr_en, reg_wr_addr, ADDR_CONFIG);
    wr_code = write_hit(reg_wr_en, reg_wr_addr, ADDR_CODE);
    wr_gain = write_hit(reg_wr_en, reg_wr_addr, ADDR_GAIN);
    wr_zero = write_hit(reg_wr_en, reg_wr_addr, ADDR_ZERO);
    wr_reset = write_hit(reg_wr_en, reg_wr_addr, ADDR_SOFT_RESET);
    range_now = control_r[CTL_RANGE_LSB +: 3];
    range_changed = wr_control &&
                    (reg_wr_data[CTL_RANGE_LSB +: 3] != range_now);
    dual_mode = config_r[CFG_DUAL];
  end

  // Only bit zero triggers; upper bits are dropped, nothing is stored
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      trigger_r <= 1'b0;
    end
    else if (trigger_r)
    begin
      trigger_r <= 1'b0;
    end
    else
    begin
      trigger_r <= wr_reset && reg_wr_data[RST_TRIGGER_BIT];
    end
  end

  // Writes in the soft reset cycle are lost; reset wins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      control_r <= CONTROL_RESET;
    end
    else if (trigger_r)
    begin
      control_r <= CONTROL_RESET;
    end
    else if (wr_control)
    begin
      control_r <= reg_wr_data & CTL_WRITE_MASK;
    end
  end

  // Reserved bits are not stored, so they always read zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      config_r <= CONFIG_RESET;
    end
    else if (trigger_r)
    begin
      config_r <= CONFIG_RESET;
    end
    else if (wr_config)
    begin
      config_r <= reg_wr_data & CFG_WRITE_MASK;
    end
  end

  // Main range change restores the code; config writes never touch it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      code_r <= CODE_RESET;
    end
    else if (trigger_r)
    begin
      code_r <= CODE_RESET;
    end
    else if (range_changed)
    begin
      code_r <= CODE_RESET;
    end
    else if (wr_code)
    begin
      code_r <= reg_wr_data & RES_MASK;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gain_r <= GAIN_RESET;
    end
    else if (trigger_r)
    begin
      gain_r <= GAIN_RESET;
    end
    else if (wr_gain)
    begin
      gain_r <= reg_wr_data & RES_MASK;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      zero_r <= ZERO_RESET;
    end
    else if (trigger_r)
    begin
      zero_r <= ZERO_RESET;
    end
    else if (wr_zero)
    begin
      zero_r <= reg_wr_data & RES_MASK;
    end
  end

  // Frame faults are events: held until a reset, not resolved by a tick
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      frame_fault_r <= 1'b0;
    end
    else if (frame_error && config_r[CFG_FRAME])
    begin
      frame_fault_r <= 1'b1;
    end
    else if (trigger_r)
    begin
      frame_fault_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      watchdog_fault_r <= 1'b0;
      loop_fault_r <= 1'b0;
      overtemp_fault_r <= 1'b0;
    end
    else
    begin
      watchdog_fault_r <= alarm_next(watchdog_fault_r,
                                     watchdog_timeout && config_r[CFG_WD_EN],
                                     monitor_tick, trigger_r);
      loop_fault_r <= alarm_next(loop_fault_r, loop_fault_cond,
                                 monitor_tick, trigger_r);
      overtemp_fault_r <= alarm_next(overtemp_fault_r, overtemp_cond,
                                     monitor_tick, trigger_r);
    end
  end

  // Slewing is a live indication, not an alarm
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      slewing_r <= 1'b0;
    end
    else
    begin
      slewing_r <= slew_busy;
    end
  end

  always_comb
  begin
    status_word = 16'h0000;
    status_word[ST_FRAME] = frame_fault_r;
    status_word[ST_WATCHDOG] = watchdog_fault_r;
    status_word[ST_LOOP] = loop_fault_r;
    status_word[ST_SLEW] = slewing_r;
    status_word[ST_TEMP] = overtemp_fault_r;
  end

  // Soft reset register is write only and reads zero like unmapped space
  always_comb
  begin
    case (reg_rd_addr)
      ADDR_CONTROL:
      begin
        rd_data_nxt = control_r;
      end
      ADDR_CONFIG:
      begin
        rd_data_nxt = config_r;
      end
      ADDR_CODE:
      begin
        rd_data_nxt = code_r & RES_MASK;
      end
      ADDR_GAIN:
      begin
        rd_data_nxt = gain_r & RES_MASK;
      end
      ADDR_ZERO:
      begin
        rd_data_nxt = zero_r & RES_MASK;
      end
      ADDR_STATUS:
      begin
        rd_data_nxt = status_word;
      end
      default:
      begin
        rd_data_nxt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data_r <= 16'h0000;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= reg_rd_en;
      if (reg_rd_en)
      begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end

  assign reg_rd_data = rd_data_r;
  assign reg_rd_valid = rd_valid_r;

  // Output enables; dual mode forces both on from the shared code
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      voltage_out_enable <= 1'b0;
      current_out_enable <= 1'b0;
    end
    else if (dual_mode)
    begin
      voltage_out_enable <= 1'b1;
      current_out_enable <= 1'b1;
    end
    else
    begin
      voltage_out_enable <= control_r[CTL_OUTEN] && !range_now[RANGE_CURRENT_BIT];
      current_out_enable <= control_r[CTL_OUTEN] && range_now[RANGE_CURRENT_BIT];
    end
  end

  // Current range only follows the select field in dual mode
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      voltage_range <= 3'h0;
      current_range <= 2'h0;
    end
    else
    begin
      voltage_range <= range_now;
      if (dual_mode)
      begin
        current_range <= config_r[CFG_CUR_RANGE_LSB +: 2];
      end
      else
      begin
        current_range <= range_now[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sense_pulldown_enable <= 1'b0;
      modem_coupling_active <= 1'b0;
      frame_check_enable <= 1'b0;
      watchdog_enable <= 1'b0;
      watchdog_period_select <= 2'h0;
    end
    else
    begin
      sense_pulldown_enable <= config_r[CFG_PULLDOWN];
      modem_coupling_active <= config_r[CFG_MODEM] &&
                               (range_now == RANGE_4_20MA);
      frame_check_enable <= config_r[CFG_FRAME];
      watchdog_enable <= config_r[CFG_WD_EN];
      watchdog_period_select <= config_r[CFG_WD_PD_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      soft_reset_active <= 1'b0;
      alarm_any <= 1'b0;
    end
    else
    begin
      soft_reset_active <= trigger_r;
      alarm_any <= frame_fault_r || watchdog_fault_r || loop_fault_r ||
                   overtemp_fault_r;
    end
  end

  // Trims are applied after the code; one cycle of latency
  dcsr_cal_path #(
    .CODE_BITS(CODE_BITS)
  ) u_cal (
    .clk(clk),
    .nrst(nrst),
    .cal_enable(config_r[CFG_CAL]),
    .code(code_r),
    .gain(gain_r),
    .zero(zero_r),
    .cal_code_r(calibrated_code)
  );

endmodule

// >>> dcsr_regs_monitor.sv
// Port checker for the register bank
`timescale 1ns/10ps
module dcsr_regs_monitor
  import dcsr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register ports
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_addr,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_addr,
  input wire logic [15:0] reg_rd_data,
  input wire logic reg_rd_valid,
  // Monitors and outputs
  input wire logic monitor_tick,
  input wire logic overtemp_cond,
  input wire logic voltage_out_enable,
  input wire logic current_out_enable,
  input wire logic [1:0] current_range,
  input wire logic sense_pulldown_enable,
  input wire logic frame_check_enable,
  input wire logic watchdog_enable,
  input wire logic [1:0] watchdog_period_select,
  input wire logic soft_reset_active,
  input wire logic alarm_any
);
  logic cfg_wr;
  logic srst_wr;
  logic rst_nop;
  assign cfg_wr = reg_wr_en && reg_wr_addr == ADDR_CONFIG;
  assign srst_wr = reg_wr_en && reg_wr_addr == ADDR_SOFT_RESET && reg_wr_data[0];
  assign rst_nop = reg_wr_en && reg_wr_addr == ADDR_SOFT_RESET && !reg_wr_data[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Writes in the edge after a soft reset are lost, hence the past guard
  a_pulldown_follow: assert property (
    (cfg_wr && !$past(srst_wr)) ##1 !reg_wr_en |=>
    sense_pulldown_enable == $past(reg_wr_data[7], 2))
    else $error("pulldown output mismatch");
  a_cfg_fields: assert property (
    (cfg_wr && !$past(srst_wr)) ##1 !reg_wr_en |=>
    {frame_check_enable, watchdog_enable, watchdog_period_select} == $past(reg_wr_data[3:0], 2))
    else $error("config field outputs mismatch");
  a_dual_outputs: assert property (
    (cfg_wr && reg_wr_data[8] && !$past(srst_wr)) ##1 !reg_wr_en |=>
    voltage_out_enable && current_out_enable && current_range == $past(reg_wr_data[10:9], 2))
    else $error("dual mode outputs mismatch");
  a_read_valid: assert property (
    reg_rd_en ##1 !reg_rd_en |-> reg_rd_valid ##1 !reg_rd_valid)
    else $error("read valid pulse wrong");
  a_status_upper: assert property (
    reg_rd_en && reg_rd_addr == ADDR_STATUS |=> reg_rd_data[15:5] == 11'h000)
    else $error("status upper bits not zero");
  a_soft_pulse: assert property (
    srst_wr ##1 !srst_wr |-> ##1 soft_reset_active ##1 !soft_reset_active)
    else $error("soft reset pulse wrong");
  a_soft_restore: assert property (
    srst_wr |-> ##3 !sense_pulldown_enable && !frame_check_enable && !watchdog_enable
    && watchdog_period_select == 2'h0)
    else $error("soft reset left config set");
  a_reserved_nop: assert property (
    rst_nop |-> ##2 !soft_reset_active)
    else $error("reserved reset bits acted");
  a_temp_alarm: assert property (
    monitor_tick && overtemp_cond |-> ##2 alarm_any)
    else $error("alarm summary not raised");
endmodule

bind dcsr_regs dcsr_regs_monitor mon (.*);

// >>> testbench.sv
// Self-checking testbench for the register bank
`timescale 1ns/10ps
module testbench;
  import dcsr_pkg::*;
  logic clk;
  logic nrst;
  logic reg_wr_en;
  logic [7:0] reg_wr_addr;
  logic [15:0] reg_wr_data;
  logic reg_rd_en;
  logic [7:0] reg_rd_addr;
  logic [15:0] reg_rd_data;
  logic reg_rd_valid;
  logic monitor_tick;
  logic frame_error;
  logic watchdog_timeout;
  logic loop_fault_cond;
  logic overtemp_cond;
  logic slew_busy;
  logic voltage_out_enable;
  logic current_out_enable;
  logic [2:0] voltage_range;
  logic [1:0] current_range;
  logic sense_pulldown_enable;
  logic modem_coupling_active;
  logic frame_check_enable;
  logic watchdog_enable;
  logic [1:0] watchdog_period_select;
  logic [15:0] calibrated_code;
  logic soft_reset_active;
  logic alarm_any;
  int error_cnt = 0;
  int samples_checked = 0;
  dcsr_regs dut (.*);
  dcsr_host_model host (.*);
  always #2.5 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bchk(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    host.rd(a, d, ok);
    bchk(ok, 1'b1);
    chk(d, exp);
  endtask
  task automatic pulse_tick;
    monitor_tick = 1'b1;
    cyc(1);
    monitor_tick = 1'b0;
    cyc(1);
  endtask
  task automatic test_reset;
    rchk(ADDR_CONFIG, 16'h0000);
    rchk(ADDR_CODE, 16'h0000);
    rchk(ADDR_GAIN, 16'h0000);
    rchk(ADDR_STATUS, 16'h0000);
    rchk(8'h33, 16'h0000);
    bchk(sense_pulldown_enable, 1'b0);
    $display("reset test done");
  endtask
  task automatic test_config;
    host.wr(ADDR_CONFIG, 16'h07BF);
    cyc(2);
    rchk(ADDR_CONFIG, 16'h07BF);
    bchk(sense_pulldown_enable, 1'b1);
    bchk(frame_check_enable, 1'b1);
    chk({13'h0000, watchdog_enable, watchdog_period_select}, 16'h0007);
    chk({14'h0000, voltage_out_enable, current_out_enable}, 16'h0003);
    chk({14'h0000, current_range}, 16'h0003);
    host.wr(ADDR_CONFIG, 16'h0400);
    cyc(2);
    chk({14'h0000, current_range}, 16'h0000);
    $display("config test done");
  endtask
  task automatic test_range;
    host.wr(ADDR_CONTROL, 16'h0005);
    host.wr(ADDR_CODE, 16'h1234);
    host.wr(ADDR_CONFIG, 16'h0710);
    cyc(2);
    bchk(modem_coupling_active, 1'b1);
    chk({13'h0000, voltage_range}, 16'h0005);
    chk({14'h0000, current_range}, 16'h0003);
    rchk(ADDR_CODE, 16'h1234);
    host.wr(ADDR_CONTROL, 16'h0004);
    cyc(2);
    rchk(ADDR_CODE, 16'h0000);
    bchk(modem_coupling_active, 1'b0);
    $display("range test done");
  endtask
  task automatic test_cal;
    host.wr(ADDR_CONFIG, 16'h0000);
    host.wr(ADDR_CODE, 16'h1000);
    host.wr(ADDR_GAIN, 16'hFFFF);
    host.wr(ADDR_ZERO, 16'h0010);
    cyc(3);
    chk(calibrated_code, 16'h1000);
    host.wr(ADDR_CONFIG, 16'h0020);
    cyc(3);
    chk(calibrated_code, 16'h1010);
    host.wr(ADDR_CODE, 16'h0008);
    host.wr(ADDR_ZERO, 16'hFFF0);
    cyc(3);
    chk(calibrated_code, 16'h0000);
    rchk(ADDR_ZERO, 16'hFFF0);
    host.wr(ADDR_CODE, 16'hFFFF);
    host.wr(ADDR_ZERO, 16'h0010);
    cyc(3);
    chk(calibrated_code, 16'hFFFF);
    $display("calibration test done");
  endtask
  task automatic test_alarm;
    host.wr(ADDR_CONFIG, 16'h0000);
    overtemp_cond = 1'b1;
    pulse_tick;
    overtemp_cond = 1'b0;
    rchk(ADDR_STATUS, 16'h0001);
    bchk(alarm_any, 1'b1);
    pulse_tick;
    rchk(ADDR_STATUS, 16'h0000);
    loop_fault_cond = 1'b1;
    slew_busy = 1'b1;
    watchdog_timeout = 1'b1;
    pulse_tick;
    host.wr(ADDR_STATUS, 16'hFFFF);
    rchk(ADDR_STATUS, 16'h0006);
    host.wr(ADDR_CONFIG, 16'h000C);
    pulse_tick;
    frame_error = 1'b1;
    cyc(1);
    frame_error = 1'b0;
    rchk(ADDR_STATUS, 16'h001E);
    $display("alarm test done");
  endtask
  task automatic test_soft;
    slew_busy = 1'b0;
    loop_fault_cond = 1'b0;
    host.wr(ADDR_SOFT_RESET, 16'hFFFE);
    cyc(1);
    bchk(soft_reset_active, 1'b0);
    rchk(ADDR_CONFIG, 16'h000C);
    overtemp_cond = 1'b1;
    host.wr(ADDR_SOFT_RESET, 16'h0001);
    cyc(1);
    bchk(soft_reset_active, 1'b1);
    cyc(1);
    bchk(soft_reset_active, 1'b0);
    rchk(ADDR_STATUS, 16'h0000);
    rchk(ADDR_CONFIG, 16'h0000);
    rchk(ADDR_GAIN, 16'h0000);
    pulse_tick;
    rchk(ADDR_STATUS, 16'h0001);
    $display("soft reset test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Tests need about 120 cycles; this cuts a hang short
  initial
  begin
    #50000;
    error_cnt++;
    $display("unexpected at %0t got %h exp %h", $time, 16'h0000, 16'h0001);
    final_report;
  end
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    monitor_tick = 1'b0;
    frame_error = 1'b0;
    watchdog_timeout = 1'b0;
    loop_fault_cond = 1'b0;
    overtemp_cond = 1'b0;
    slew_busy = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    test_reset;
    test_config;
    test_range;
    test_cal;
    test_alarm;
    test_soft;
    final_report;
  end
endmodule
